// >>> shared/flash_cfg.svh
// Offsets, field positions, reset values and timing counts of the flash self-program block.
`ifndef FLASH_CFG_SVH
`define FLASH_CFG_SVH

// Special function register addresses on the core link.
`define SFR_ADDR_LOW    3'h0
`define SFR_ADDR_HIGH   3'h1
`define SFR_DATA_LOW    3'h2
`define SFR_DATA_HIGH   3'h3
`define SFR_CONTROL     3'h4
`define SFR_UNLOCK_KEY  3'h5

// Bit positions inside flash_control.
`define CTL_RD          0
`define CTL_WR          1
`define CTL_PERMIT      2
`define CTL_ERR         3
`define CTL_ERASE       4
`define CTL_LATCH       5
`define CTL_CONFIG_SPACE_SELECT        6

`define CTL_RESET       8'h00
`define KEY_FIRST       8'h55
`define KEY_SECOND      8'haa
`define BLANK_WORD      14'h3fff

// Array organisation: 32-word rows, 2048 words.
`define ROW_WORDS       32
`define ROW_BITS        5
`define MEM_WORDS       2048
`define MEM_ABITS       11

// Erase and program time, and the rate of pclk.
`define OP_TIME_US      2000
`define CLK_MHZ         40
`define STALL_CNT_W     17

// APB register map of the core port.
`define APB_CMD         12'h000
`define APB_STATUS      12'h004
`define CMD_READ_BIT    11

`endif

// >>> shared/flash_pkg.sv
// Types shared by both ends of the flash self-program link.
package flash_pkg;

  typedef enum logic [5:0] {
    op_idle  = 6'h01,
    op_read1 = 6'h02,
    op_read2 = 6'h04,
    op_nop1  = 6'h08,
    op_nop2  = 6'h10,
    op_stall = 6'h20
  } op_state_e;

  typedef enum logic [2:0] {
    key_idle  = 3'h1,
    key_got55 = 3'h2,
    key_armed = 3'h4
  } key_state_e;

endpackage

// >>> shared/flash_link_if.sv
// Link between the core port and the flash self-program controller.
interface flash_link_if;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [2:0] sfr_addr;
  logic [7:0] sfr_wdata;
  logic [7:0] sfr_rdata;
  logic       rdata_valid;
  logic       nop_slot;
  logic       stall;

  modport device (
    input  sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
    output sfr_rdata, rdata_valid, nop_slot, stall
  );

  modport core (
    output sfr_wr, sfr_rd, sfr_addr, sfr_wdata,
    input  sfr_rdata, rdata_valid, nop_slot, stall
  );
endinterface

// >>> hdl/flash_row_self_program.sv
// Flash self-program controller: registers, unlock, read, latch load, erase and program.
//
// Our own choices: the APB register port and the register offsets.
`include "flash_cfg.svh"

module flash_row_self_program
  import flash_pkg::*;
#(
  parameter int ERASE_CYCLES = `OP_TIME_US * `CLK_MHZ
) (
  // Clock and resets.
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    por_n,
  // Core link.
  flash_link_if.device link,
  // Status.
  output logic         flash_busy
);

  logic [13:0] mem   [0:`MEM_WORDS-1];
  logic [13:0] latch [0:`ROW_WORDS-1];

  logic [7:0]             addr_low;
  logic [6:0]             addr_high;
  logic [7:0]             data_low;
  logic [5:0]             data_high;
  logic                   rd_busy;
  logic                   wr_busy;
  logic                   permit;
  logic                   erase_sel;
  logic                   latch_only;
  logic                   config_space_select;
  logic                   err_flag;
  logic                   wr_mark;
  logic                   run;
  logic                   run_d;
  logic [`STALL_CNT_W-1:0] stall_cnt;
  op_state_e              op_q;
  op_state_e              next_op;
  key_state_e             key_q;
  key_state_e             next_key;
  logic [7:0]             ctl_view;
  logic [7:0]             rd_mux;

  function automatic logic [`MEM_ABITS-1:0] word_at(input logic [`MEM_ABITS-`ROW_BITS-1:0] row,
                                                    input logic [`ROW_BITS-1:0] col);
    word_at = {row, col};
  endfunction

  wire [14:0] flash_addr = {addr_high, addr_low};
  wire [`MEM_ABITS-`ROW_BITS-1:0] row_sel = flash_addr[`MEM_ABITS-1:`ROW_BITS];
  wire [`ROW_BITS-1:0] col_sel = flash_addr[`ROW_BITS-1:0];
  wire take      = (link.sfr_wr | link.sfr_rd) & ~link.nop_slot & ~link.stall;
  wire wr_take   = take & link.sfr_wr;
  wire rd_take   = take & ~link.sfr_wr;
  wire sel_alow  = link.sfr_addr == `SFR_ADDR_LOW;
  wire sel_ahigh = link.sfr_addr == `SFR_ADDR_HIGH;
  wire sel_dlow  = link.sfr_addr == `SFR_DATA_LOW;
  wire sel_dhigh = link.sfr_addr == `SFR_DATA_HIGH;
  wire sel_ctl   = link.sfr_addr == `SFR_CONTROL;
  wire sel_key   = link.sfr_addr == `SFR_UNLOCK_KEY;
  wire ctl_wr    = wr_take & sel_ctl;
  wire op_free   = op_q == op_idle;
  // A write-start only counts right after both keys and with permission.
  wire start_write = ctl_wr & link.sfr_wdata[`CTL_WR] & (key_q == key_armed) & op_free
                   & link.sfr_wdata[`CTL_PERMIT] & ~link.sfr_wdata[`CTL_CONFIG_SPACE_SELECT];
  wire start_read  = ctl_wr & link.sfr_wdata[`CTL_RD] & op_free & ~start_write;
  wire stall_done  = stall_cnt == '0;
  wire [13:0] read_word = config_space_select ? 14'h0000 : mem[flash_addr[`MEM_ABITS-1:0]];

  // Unlock tracker: any access other than the expected next step disarms it.
  always_comb begin
    next_key = key_q;
    if (take) begin
      if (wr_take && sel_key && link.sfr_wdata == `KEY_FIRST) begin
        next_key = key_got55;
      end else if (wr_take && sel_key && link.sfr_wdata == `KEY_SECOND &&
                   key_q == key_got55) begin
        next_key = key_armed;
      end else begin
        next_key = key_idle;
      end
    end
  end

  always_comb begin
    next_op = op_q;
    case (op_q)
      op_idle: begin
        if (start_write) begin
          next_op = op_nop1;
        end else if (start_read) begin
          next_op = op_read1;
        end
      end
      op_read1: next_op = op_read2;
      op_read2: next_op = op_idle;
      op_nop1:  next_op = op_nop2;
      op_nop2:  next_op = latch_only ? op_idle : op_stall;
      op_stall: next_op = stall_done ? op_idle : op_stall;
      default:  next_op = op_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q          <= op_idle;
      key_q         <= key_idle;
      link.nop_slot <= 1'b0;
      link.stall    <= 1'b0;
      flash_busy    <= 1'b0;
      run           <= 1'b0;
      run_d         <= 1'b0;
    end else begin
      op_q          <= next_op;
      key_q         <= next_key;
      link.nop_slot <= next_op == op_read2 || next_op == op_nop1 || next_op == op_nop2;
      link.stall    <= next_op == op_stall;
      flash_busy    <= next_op != op_idle;
      run           <= 1'b1;
      run_d         <= run;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_cnt <= '0;
    end else if (op_q == op_nop2) begin
      stall_cnt <= `STALL_CNT_W'(ERASE_CYCLES - 1);
    end else if (op_q == op_stall && !stall_done) begin
      stall_cnt <= stall_cnt - 1'b1;
    end
  end

  // Address, data and control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_low   <= 8'h00;
      addr_high  <= 7'h00;
      data_low   <= 8'h00;
      data_high  <= 6'h00;
      {config_space_select, latch_only, erase_sel, permit} <= 4'h0;
      rd_busy    <= 1'b0;
      wr_busy    <= 1'b0;
    end else begin
      if (wr_take && sel_alow) addr_low <= link.sfr_wdata;
      if (wr_take && sel_ahigh) addr_high <= link.sfr_wdata[6:0];
      if (op_q == op_read2) begin
        {data_high, data_low} <= read_word;
      end else begin
        if (wr_take && sel_dlow) data_low <= link.sfr_wdata;
        if (wr_take && sel_dhigh) data_high <= link.sfr_wdata[5:0];
      end
      if (ctl_wr) begin
        permit     <= link.sfr_wdata[`CTL_PERMIT];
        erase_sel  <= link.sfr_wdata[`CTL_ERASE];
        latch_only <= link.sfr_wdata[`CTL_LATCH];
        config_space_select       <= link.sfr_wdata[`CTL_CONFIG_SPACE_SELECT];
      end
      // Start bits: software may only set them, hardware clears at the end.
      if (start_read) rd_busy <= 1'b1;
      else if (op_q == op_read2) rd_busy <= 1'b0;
      if (start_write) wr_busy <= 1'b1;
      else if (next_op == op_idle && !op_free && op_q != op_read2) wr_busy <= 1'b0;
    end
  end

  // The flag and its marker survive a warm reset; power-up clears both, and a control write with CTL_ERR low clears the flag.
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      wr_mark  <= 1'b0;
      err_flag <= 1'b0;
    end else if (run && !run_d) begin
      err_flag <= err_flag | wr_mark;
      wr_mark  <= 1'b0;
    end else if (run) begin
      wr_mark <= wr_busy;
      if (ctl_wr && !link.sfr_wdata[`CTL_ERR]) err_flag <= 1'b0;
    end
  end

  // Write latches: loaded one word per unlocked latch-load write, blanked after erase or program.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `ROW_WORDS; i++) latch[i] <= `BLANK_WORD;
    end else if (op_q == op_nop1 && latch_only) begin
      latch[col_sel] <= {data_high, data_low};
    end else if (op_q == op_stall && stall_done) begin
      for (int i = 0; i < `ROW_WORDS; i++) latch[i] <= `BLANK_WORD;
    end
  end

  // Array update at the end of the stall; programming only clears bits.
  always_ff @(posedge pclk) begin
    if (op_q == op_stall && stall_done) begin
      for (int i = 0; i < `ROW_WORDS; i++) begin
        if (erase_sel) begin
          mem[word_at(row_sel, `ROW_BITS'(i))] <= `BLANK_WORD;
        end else begin
          mem[word_at(row_sel, `ROW_BITS'(i))] <=
            mem[word_at(row_sel, `ROW_BITS'(i))] & latch[i];
        end
      end
    end
  end

  always_comb begin
    ctl_view              = `CTL_RESET;
    ctl_view[`CTL_RD]     = rd_busy;
    ctl_view[`CTL_WR]     = wr_busy;
    ctl_view[`CTL_PERMIT] = permit;
    ctl_view[`CTL_ERR]    = err_flag;
    ctl_view[`CTL_ERASE]  = erase_sel;
    ctl_view[`CTL_LATCH]  = latch_only;
    ctl_view[`CTL_CONFIG_SPACE_SELECT]   = config_space_select;
  end

  assign rd_mux = sel_alow  ? addr_low :
                  sel_ahigh ? {1'b0, addr_high} :
                  sel_dlow  ? data_low :
                  sel_dhigh ? {2'b00, data_high} :
                  sel_ctl   ? ctl_view : 8'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sfr_rdata   <= 8'h00;
      link.rdata_valid <= 1'b0;
    end else begin
      link.rdata_valid <= rd_take;
      if (rd_take) link.sfr_rdata <= rd_mux;
    end
  end

endmodule // flash_row_self_program

// >>> hdl/flash_cpu_port.sv
// Core end of the flash link: takes APB orders and issues special function register accesses.
`include "flash_cfg.svh"

module flash_cpu_port
  import flash_pkg::*;
(
  // Clock and reset.
  input  wire logic    pclk,
  input  wire logic    presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Flash link.
  flash_link_if.core   link
);

  logic       pending;
  logic       is_read;
  logic       waiting_data;
  logic [7:0] last_rdata;

  wire setup      = psel & ~penable & ~pready;
  wire hit_cmd    = paddr == `APB_CMD;
  wire hit_status = paddr == `APB_STATUS;
  wire cmd_write  = setup & pwrite & hit_cmd & ~pending;
  wire active     = link.sfr_wr | link.sfr_rd;
  // An access is only taken in a slot that is neither squashed nor stalled.
  wire accepted   = active & ~link.nop_slot & ~link.stall;
  wire [31:0] status_word = {16'h0000, last_rdata, 4'h0, waiting_data, link.stall,
                             link.nop_slot, pending};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_cmd & ~hit_status;
      if (setup && !pwrite) prdata <= hit_status ? status_word : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending        <= 1'b0;
      is_read        <= 1'b0;
      link.sfr_wr    <= 1'b0;
      link.sfr_rd    <= 1'b0;
      link.sfr_addr  <= 3'h0;
      link.sfr_wdata <= 8'h00;
    end else if (cmd_write) begin
      pending        <= 1'b1;
      is_read        <= pwdata[`CMD_READ_BIT];
      link.sfr_addr  <= pwdata[10:8];
      link.sfr_wdata <= pwdata[7:0];
      link.sfr_wr    <= ~pwdata[`CMD_READ_BIT];
      link.sfr_rd    <= pwdata[`CMD_READ_BIT];
    end else if (accepted) begin
      pending     <= 1'b0;
      link.sfr_wr <= 1'b0;
      link.sfr_rd <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waiting_data <= 1'b0;
      last_rdata   <= 8'h00;
    end else if (link.rdata_valid) begin
      waiting_data <= 1'b0;
      last_rdata   <= link.sfr_rdata;
    end else if (accepted && is_read) begin
      waiting_data <= 1'b1;
    end
  end

endmodule // flash_cpu_port

// >>> tb/flash_link_monitor.sv
// Assertions on the link between the core port and the flash self-program controller.
`include "flash_cfg.svh"

module flash_link_monitor #(
  parameter int ERASE_CYCLES = 8
) (
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Link signals.
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [2:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic       rdata_valid,
  input wire logic       nop_slot,
  input wire logic       stall
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  key_q;
  logic        rd_prev;
  logic [16:0] stall_cnt;
  wire         take    = (sfr_wr | sfr_rd) & ~nop_slot & ~stall;
  wire         rd_take = sfr_rd & take;
  wire         ctl_wr  = sfr_wr & take & (sfr_addr == `SFR_CONTROL);
  wire         key_wr  = sfr_wr & take & (sfr_addr == `SFR_UNLOCK_KEY);
  wire         rd_go   = ctl_wr & sfr_wdata[`CTL_RD] & ~sfr_wdata[`CTL_WR] & ~rd_prev;
  wire         wr_try  = ctl_wr & sfr_wdata[`CTL_WR] & ~sfr_wdata[`CTL_RD] & ~rd_prev;
  wire         wr_go   = wr_try & (key_q == 2'h2) & sfr_wdata[`CTL_PERMIT]
                         & ~sfr_wdata[`CTL_CONFIG_SPACE_SELECT];

  // Tracks the key writes the way the controller should, so starts can be predicted.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_q     <= 2'h0;
      rd_prev   <= 1'b0;
      stall_cnt <= 17'h0;
    end else begin
      rd_prev   <= rd_go;
      stall_cnt <= stall ? stall_cnt + 17'h1 : 17'h0;
      if (take) begin
        key_q <= (key_wr && sfr_wdata == `KEY_FIRST) ? 2'h1 :
                 (key_wr && key_q == 2'h1 && sfr_wdata == `KEY_SECOND) ? 2'h2 : 2'h0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence two_nops;
    nop_slot [*2];
  endsequence
  sequence read_slots;
    !nop_slot ##1 nop_slot ##1 !nop_slot;
  endsequence

  rd_answer_a: assert property (rd_take |=> rdata_valid)
    else $error("read access not answered");
  valid_cause_a: assert property (rdata_valid |-> $past(rd_take))
    else $error("read data without a request");
  key_zero_a: assert property (rd_take && sfr_addr == `SFR_UNLOCK_KEY |=> sfr_rdata == 8'h00)
    else $error("key port read not zero");
  read_slot_a: assert property (rd_go |=> read_slots)
    else $error("read slot timing wrong");
  wr_nop_a: assert property (wr_go |=> two_nops)
    else $error("no forced slots after write start");
  erase_stall_a: assert property (wr_go && !sfr_wdata[`CTL_LATCH] |=> two_nops ##1 stall)
    else $error("erase did not stall");
  latch_go_a: assert property (wr_go && sfr_wdata[`CTL_LATCH] |=> two_nops ##1 !stall)
    else $error("latch load stalled");
  no_unlock_a: assert property (wr_try && !wr_go |=> !nop_slot ##1 !stall)
    else $error("write started without unlock");
  stall_len_a: assert property ($fell(stall) |-> stall_cnt == 17'(ERASE_CYCLES))
    else $error("stall length wrong");
  stall_quiet_a: assert property (stall |=> !rdata_valid)
    else $error("access taken during stall");
endmodule // flash_link_monitor

// >>> tb/tb_top.sv
// Self-checking bench joining the core port and the flash controller across their link.
`include "flash_cfg.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ERASE_CYCLES = 8;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr, flash_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        err_q;
  int          errors, n_checks, cycles;

  flash_link_if link ();
  flash_cpu_port flash_cpu_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .link(link));
  flash_row_self_program #(.ERASE_CYCLES(ERASE_CYCLES)) flash_row_self_program_inst (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .link(link), .flash_busy(flash_busy));
  flash_link_monitor #(.ERASE_CYCLES(ERASE_CYCLES)) flash_link_monitor_inst (.pclk(pclk),
    .presetn(presetn), .sfr_wr(link.sfr_wr), .sfr_rd(link.sfr_rd), .sfr_addr(link.sfr_addr),
    .sfr_wdata(link.sfr_wdata), .sfr_rdata(link.sfr_rdata), .rdata_valid(link.rdata_valid),
    .nop_slot(link.nop_slot), .stall(link.stall));

  always #12.5 pclk = ~pclk;

  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits for pready with no limit of its own; the cycle ceiling ends a hang.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q       = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // One register access on the link, then wait until the core port is idle again.
  task automatic sfr(input logic rd, input logic [2:0] a, input logic [7:0] d);
    int n;
    n = 0;
    apb(1'b1, `APB_CMD, {20'h0_0000, rd, a, d});
    do begin
      apb(1'b0, `APB_STATUS, 32'h0000_0000);
      n++;
    end while ((q[0] !== 1'b0 || q[3] !== 1'b0) && n < 100);
    if (n == 100) errors++;
  endtask

  task automatic unlock(input logic [7:0] ctl);
    sfr(1'b0, `SFR_UNLOCK_KEY, `KEY_FIRST);
    sfr(1'b0, `SFR_UNLOCK_KEY, `KEY_SECOND);
    sfr(1'b0, `SFR_CONTROL, ctl);
  endtask

  task automatic set_addr(input logic [14:0] a);
    sfr(1'b0, `SFR_ADDR_LOW, a[7:0]);
    sfr(1'b0, `SFR_ADDR_HIGH, {1'b0, a[14:8]});
  endtask

  task automatic read_word(input logic [14:0] a, input logic [13:0] exp);
    logic [7:0] lo;
    set_addr(a);
    sfr(1'b0, `SFR_CONTROL, 8'h01);
    sfr(1'b1, `SFR_DATA_LOW, 8'h00);
    lo = q[15:8];
    sfr(1'b1, `SFR_DATA_HIGH, 8'h00);
    check(32'({q[13:8], lo}), 32'(exp));
  endtask

  task automatic load_latch(input logic [14:0] a, input logic [13:0] d);
    set_addr(a);
    sfr(1'b0, `SFR_DATA_LOW, d[7:0]);
    sfr(1'b0, `SFR_DATA_HIGH, {2'h0, d[13:8]});
    unlock(8'h26);
  endtask

  task automatic t_reset();
    sfr(1'b1, `SFR_CONTROL, 8'h00);
    check(32'(q[15:8]), 32'h0000_0000);
    sfr(1'b1, `SFR_UNLOCK_KEY, 8'h00);
    check(32'(q[15:8]), 32'h0000_0000);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check({31'h0, err_q}, 32'h0000_0001);
    check(q, 32'h0000_0000);
  endtask

  task automatic t_erase();
    set_addr(15'h0123);
    unlock(8'h16);
    check(32'(flash_busy), 32'h0000_0001);
    sfr(1'b1, `SFR_CONTROL, 8'h00);
    check(32'(q[15:8]), 32'h0000_0014);
    check(32'(flash_busy), 32'h0000_0000);
    read_word(15'h0120, 14'h3fff);
    read_word(15'h013f, 14'h3fff);
  endtask

  task automatic t_program();
    load_latch(15'h0122, 14'h1a5c);
    unlock(8'h06);
    read_word(15'h0122, 14'h1a5c);
    read_word(15'h0123, 14'h3fff);
    load_latch(15'h0123, 14'h0f0f);
    unlock(8'h06);
    read_word(15'h0123, 14'h0f0f);
    read_word(15'h0122, 14'h1a5c);
  endtask

  task automatic t_bad_unlock();
    set_addr(15'h0122);
    sfr(1'b0, `SFR_UNLOCK_KEY, `KEY_FIRST);
    sfr(1'b1, `SFR_UNLOCK_KEY, 8'h00);
    sfr(1'b0, `SFR_UNLOCK_KEY, `KEY_SECOND);
    sfr(1'b0, `SFR_CONTROL, 8'h16);
    unlock(8'h12);
    unlock(8'h56);
    read_word(15'h0122, 14'h1a5c);
    sfr(1'b0, `SFR_DATA_LOW, 8'h77);
    sfr(1'b1, `SFR_DATA_LOW, 8'h00);
    check(32'(q[15:8]), 32'h0000_0077);
  endtask

  task automatic t_interrupt();
    set_addr(15'h0400);
    sfr(1'b0, `SFR_UNLOCK_KEY, `KEY_FIRST);
    sfr(1'b0, `SFR_UNLOCK_KEY, `KEY_SECOND);
    apb(1'b1, `APB_CMD, {20'h0_0000, 1'b0, 3'(`SFR_CONTROL), 8'h16});
    repeat (6) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    sfr(1'b1, `SFR_CONTROL, 8'h00);
    check(32'(q[15:8]), 32'h0000_0008);
  endtask

  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    por_n   = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    por_n   <= 1'b1;
    t_reset();
    t_erase();
    t_program();
    t_bad_unlock();
    t_interrupt();
    finish_test();
  end
endmodule // tb_top
